// file: hw/amsf_flag_latch.sv
// Per-conversion fault latch: gathers faults during a cycle, publishes them at its end
`timescale 1ns/1ps
module amsf_flag_latch #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input  wire logic             ref_clk_i,
    input  wire logic             rst_n_i,
    // Fault sampling
    input  wire logic             enable_i,
    input  wire logic [WIDTH-1:0] fault_i,
    input  wire logic             conv_end_i,
    // Published flags
    output logic      [WIDTH-1:0] flags_o
);
    import amsf_pkg::*;

    logic [WIDTH-1:0] acc_q;
    logic [WIDTH-1:0] acc_d;
    logic [WIDTH-1:0] flags_q;
    logic [WIDTH-1:0] flags_d;
    logic [WIDTH-1:0] seen;

    if (WIDTH < 1) begin : g_width_check
        $error("amsf_flag_latch: WIDTH must be at least 1");
    end

    // Faults count only while the monitor is running
    assign seen = enable_i ? fault_i : '0;

    // Accumulate during the cycle, set or clear flags only at its end
    always_comb begin
        acc_d   = acc_q | seen;
        flags_d = flags_q;
        if (conv_end_i) begin
            flags_d = acc_q | seen;
            acc_d   = '0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_q   <= '0;
            flags_q <= '0;
        end else begin
            acc_q   <= acc_d;
            flags_q <= flags_d;
        end
    end

    assign flags_o = flags_q;

endmodule : amsf_flag_latch

// file: hw/amsf_monitor.sv
// Bias, system monitor routing and fault status register of the converter
//
// Overview of operation
// R01 - Bias level bit picks half or twelfth
// R02 - Each input gets bias under own enable
// R03 - Host waits for bias settling before converting
// R04 - Selector 010 routes temperature sensor, inputs off
// R05 - Host limits gain to four for temperature
// R06 - Selector 011 analog, 100 digital supply quarter
// R07 - Supply monitor disconnects inputs, forces unity gain
// R08 - Selectors 101/110/111 enable burn-out currents
// R09 - Burn-out sources positive, sinks negative input
// R10 - Host disables chop, uses burn-out sparingly
// R11 - Status at 01h, optionally prepended
// R12 - Status read returns last conversion flags
// R13 - Power-on flag set at reset, cleared by zero
// R14 - Ready bit shows startup done, config accepted
// R15 - Four rail flags on bits five to two
// R16 - Rail monitors run only when enabled
// R17 - Rail faults latched, flags updated at end
// R18 - Reference low flags on bits zero, one
// R19 - Reference detection runs when field nonzero
// R20 - Optional pull-together resistor across reference
// R21 - Reference flags update at data-ready fall
// R22 - Selector 001 shorts input to mid-scale
// R23 - Selector 000 keeps normal input routing
`timescale 1ns/1ps
module amsf_monitor #(
    parameter int READY_CYC = amsf_pkg::READY_DELAY_CYC
) (
    // Clock and reset
    input  wire logic               ref_clk_i,
    input  wire logic               rst_n_i,
    // Register access port
    input  wire logic               reg_wr_i,
    input  wire logic               reg_rd_i,
    input  wire logic [7:0]         reg_addr_i,
    input  wire logic [7:0]         reg_wdata_i,
    output logic      [7:0]         reg_rdata_o,
    output logic                    reg_rvalid_o,
    // Converter interface
    input  wire logic               data_ready_n_i,
    input  wire logic [2:0]         pga_gain_i,
    input  wire amsf_pkg::amsf_fault_s fault_i,
    // Analog controls and status byte for data reads
    output amsf_pkg::amsf_ctl_s     ctl_o,
    output logic      [7:0]         status_byte_o
);
    import amsf_pkg::*;

    if (READY_CYC < 1) begin : g_ready_check
        $error("amsf_monitor: READY_CYC must be at least 1");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Startup and register map

    localparam int RCW = $clog2(READY_CYC + 1);
    localparam logic [RCW-1:0] READY_LAST = RCW'(READY_CYC);

    logic [RCW-1:0] start_cnt_q;
    logic [RCW-1:0] start_cnt_d;
    logic           ready_q;
    logic           ready_d;
    logic           por_q;
    logic           por_d;
    logic [7:0]     refctl_q;
    logic [7:0]     refctl_d;
    logic [7:0]     exc1_q;
    logic [7:0]     exc1_d;
    logic [7:0]     bias_q;
    logic [7:0]     bias_d;
    logic [7:0]     sysctl_q;
    logic [7:0]     sysctl_d;
    logic [7:0]     rdata_q;
    logic [7:0]     rdata_d;
    logic           rvalid_q;
    logic           rvalid_d;
    logic           wr_ok;
    logic [7:0]     status;

    // Address match used by both the write and the read decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    // Writes are ignored until the register map has come out of reset
    assign wr_ok = reg_wr_i && ready_q; // R14

    // Startup counter, power-on flag and writable registers
    always_comb begin
        start_cnt_d = start_cnt_q;
        ready_d     = ready_q;
        if (!ready_q) begin
            start_cnt_d = start_cnt_q + RCW'(1);
            ready_d     = (start_cnt_q + RCW'(1)) == READY_LAST; // R14
        end
        por_d    = por_q;
        refctl_d = refctl_q;
        exc1_d   = exc1_q;
        bias_d   = bias_q;
        sysctl_d = sysctl_q;
        // Only a written zero clears the power-on flag; a one leaves it
        if (wr_ok && hit(reg_addr_i, ADDR_STATUS) && !reg_wdata_i[STAT_POR_BIT]) begin
            por_d = 1'b0; // R13
        end
        if (wr_ok && hit(reg_addr_i, ADDR_REFCTL)) refctl_d = reg_wdata_i;
        if (wr_ok && hit(reg_addr_i, ADDR_EXC1))   exc1_d   = reg_wdata_i;
        if (wr_ok && hit(reg_addr_i, ADDR_BIAS))   bias_d   = reg_wdata_i;
        if (wr_ok && hit(reg_addr_i, ADDR_SYSCTL)) sysctl_d = reg_wdata_i;
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            start_cnt_q <= '0;
            ready_q     <= 1'b0;
            por_q       <= 1'b1; // R13
            refctl_q    <= RST_REFCTL;
            exc1_q      <= RST_EXC1;
            bias_q      <= RST_BIAS;
            sysctl_q    <= RST_SYSCTL;
        end else begin
            start_cnt_q <= start_cnt_d;
            ready_q     <= ready_d;
            por_q       <= por_d;
            refctl_q    <= refctl_d;
            exc1_q      <= exc1_d;
            bias_q      <= bias_d;
            sysctl_q    <= sysctl_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Conversion end and fault flags

    logic                dr_n_q;
    logic                dr_n_d;
    logic                conv_end;
    logic [NUM_RAIL-1:0] rail_flags;
    logic [NUM_REF-1:0]  ref_flags;
    logic [1:0]          ref_en_field;

    assign dr_n_d       = data_ready_n_i;
    assign conv_end     = dr_n_q && !data_ready_n_i; // R21
    assign ref_en_field = refctl_q[REFCTL_EN_LSB +: 2];

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dr_n_q <= 1'b1;
        end else begin
            dr_n_q <= dr_n_d;
        end
    end

    // Rail monitors gated by their enable bit
    amsf_flag_latch #(
        .WIDTH (NUM_RAIL)
    ) u_rail_latch (
        .ref_clk_i  (ref_clk_i),
        .rst_n_i    (rst_n_i),
        .enable_i   (exc1_q[EXC1_RAIL_BIT]), // R16
        .fault_i    (fault_i.rail),
        .conv_end_i (conv_end), // R17
        .flags_o    (rail_flags)
    );

    // Reference detection runs while its enable field is nonzero
    amsf_flag_latch #(
        .WIDTH (NUM_REF)
    ) u_ref_latch (
        .ref_clk_i  (ref_clk_i),
        .rst_n_i    (rst_n_i),
        .enable_i   (ref_en_field != REFEN_OFF), // R19
        .fault_i    (fault_i.ref_low),
        .conv_end_i (conv_end), // R21
        .flags_o    (ref_flags)
    );

    // Status byte assembled from latched flags
    always_comb begin
        status                                  = '0;
        status[STAT_POR_BIT]                    = por_q; // R13
        status[STAT_RDY_BIT]                    = ready_q; // R14
        status[STAT_RAIL_LSB +: NUM_RAIL]       = rail_flags; // R15
        status[STAT_REF_LSB +: NUM_REF]         = ref_flags; // R18
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register read port

    // Read data is registered and valid one cycle after the strobe
    always_comb begin
        rvalid_d = reg_rd_i;
        rdata_d  = rdata_q;
        if (reg_rd_i) begin
            unique case (1'b1)
                hit(reg_addr_i, ADDR_STATUS): rdata_d = status; // R11 R12
                hit(reg_addr_i, ADDR_REFCTL): rdata_d = refctl_q;
                hit(reg_addr_i, ADDR_EXC1):   rdata_d = exc1_q;
                hit(reg_addr_i, ADDR_BIAS):   rdata_d = bias_q;
                hit(reg_addr_i, ADDR_SYSCTL): rdata_d = sysctl_q;
                default:                      rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q  <= '0;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign reg_rdata_o   = rdata_q;
    assign reg_rvalid_o  = rvalid_q;
    assign status_byte_o = status; // R11

    ////////////////////////////////////////////////////////////////////////////
    // Analog routing from the register fields

    amsf_mon_e mon_sel;
    amsf_ctl_s ctl;

    assign mon_sel = amsf_mon_e'(sysctl_q[SYSCTL_MON_LSB +: 3]);

    // Decode the monitor selector into switch controls
    always_comb begin
        ctl                   = '0;
        ctl.bias_level_select = bias_q[BIAS_LEVEL_BIT]; // R01
        ctl.bias_input_route  = bias_q[NUM_ROUTE-1:0]; // R02
        ctl.rail_mon_en       = exc1_q[EXC1_RAIL_BIT]; // R16
        ctl.ref_det_en        = ref_en_field != REFEN_OFF; // R19
        ctl.ref_pull_res      = ref_en_field == REFEN_RESISTOR; // R20
        ctl.prepend_status    = sysctl_q[SYSCTL_PREP_BIT]; // R11
        ctl.inputs_connect    = 1'b1;
        ctl.eff_gain          = pga_gain_i;
        unique case (mon_sel)
            MON_NONE: ctl.inputs_connect = 1'b1; // R23
            MON_SHORT: begin
                ctl.inputs_connect = 1'b0;
                ctl.mid_short      = 1'b1; // R22
            end
            MON_TEMP: begin
                ctl.inputs_connect = 1'b0;
                ctl.temp_sense     = 1'b1; // R04
            end
            MON_AVDD: begin
                ctl.inputs_connect = 1'b0; // R07
                ctl.avdd_mon       = 1'b1; // R06
                ctl.eff_gain       = GAIN_UNITY; // R07
            end
            MON_DVDD: begin
                ctl.inputs_connect = 1'b0; // R07
                ctl.dvdd_mon       = 1'b1; // R06
                ctl.eff_gain       = GAIN_UNITY; // R07
            end
            MON_BO_02, MON_BO_1, MON_BO_10: begin
                ctl.burnout_current = (mon_sel == MON_BO_02) ? BO_02 :
                                      (mon_sel == MON_BO_1)  ? BO_1 : BO_10; // R08
                ctl.bo_source_p     = 1'b1; // R09
                ctl.bo_sink_n       = 1'b1; // R09
            end
        endcase
    end

    assign ctl_o = ctl;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    // Fault on rail bit 0 seen since the last conversion end, kept apart from the flag latch
    logic rail_seen_q;
    logic rail_seen_d;
    assign rail_seen_d = !conv_end
                         && (rail_seen_q || (exc1_q[EXC1_RAIL_BIT] && fault_i.rail[0]));
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rail_seen_q <= 1'b0;
        end else begin
            rail_seen_q <= rail_seen_d;
        end
    end

    sequence s_conv_end;
        dr_n_q && !data_ready_n_i;
    endsequence
    sequence s_rail_fault_seen;
        rail_seen_q || (exc1_q[EXC1_RAIL_BIT] && fault_i.rail[0]);
    endsequence

    a_por_clear_zero: assert property ( // R13
        (wr_ok && reg_addr_i == ADDR_STATUS && !reg_wdata_i[STAT_POR_BIT]) |=> !por_q
    ) else $error("power-on flag not cleared by zero write");
    a_por_sticky_one: assert property ( // R13
        !por_q |=> !por_q
    ) else $error("power-on flag set again without reset");
    a_ready_holds_flag: assert property ( // R14
        $rose(ready_q) |-> $past(start_cnt_q) == READY_LAST - RCW'(1)
    ) else $error("ready raised at wrong count");
    a_rail_flag_stable: assert property ( // R17
        !conv_end |=> $stable(rail_flags)
    ) else $error("rail flags changed outside conversion end");
    a_rail_fault_caught: assert property ( // R17
        s_rail_fault_seen ##0 s_conv_end |=> status[STAT_RAIL_LSB]
    ) else $error("rail fault lost before conversion end");
    a_ref_off_clear: assert property ( // R19
        (ref_en_field == REFEN_OFF) [*2] ##0 s_conv_end |=> ref_flags == '0
    ) else $error("reference flags set while detection off");
    a_ref_update_edge: assert property ( // R21
        $changed(ref_flags) |-> $past(conv_end)
    ) else $error("reference flags updated away from data-ready fall");
    a_supply_unity_gain: assert property ( // R07
        (mon_sel == MON_AVDD || mon_sel == MON_DVDD)
        |-> ctl_o.eff_gain == GAIN_UNITY && !ctl_o.inputs_connect
    ) else $error("supply monitor did not force unity gain");
    a_temp_inputs_off: assert property ( // R04
        mon_sel == MON_TEMP |-> ctl_o.temp_sense && !ctl_o.inputs_connect
        && ctl_o.eff_gain == pga_gain_i
    ) else $error("temperature routing wrong");
    a_burnout_level: assert property ( // R08
        mon_sel == MON_BO_10 |-> ctl_o.burnout_current == BO_10 && ctl_o.bo_sink_n
    ) else $error("burn-out level wrong");
    a_status_read_data: assert property ( // R12
        (reg_rd_i && reg_addr_i == ADDR_STATUS) |=> reg_rvalid_o && reg_rdata_o == $past(status)
    ) else $error("status read returned wrong byte");
    a_write_before_ready: assert property ( // R14
        (!ready_q && reg_wr_i && reg_addr_i == ADDR_BIAS) |=> $stable(bias_q)
    ) else $error("configuration accepted before ready");

endmodule : amsf_monitor

// file: shared/amsf_pkg.sv
// Register map, field layout and carrier types for the monitor and status flag block
package amsf_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_STATUS = 8'h01;
    localparam logic [7:0] ADDR_REFCTL = 8'h05;
    localparam logic [7:0] ADDR_EXC1   = 8'h06;
    localparam logic [7:0] ADDR_BIAS   = 8'h08;
    localparam logic [7:0] ADDR_SYSCTL = 8'h09;

    // Field positions
    localparam int STAT_POR_BIT    = 7;
    localparam int STAT_RDY_BIT    = 6;
    localparam int STAT_RAIL_LSB   = 2;
    localparam int STAT_REF_LSB    = 0;
    localparam int REFCTL_EN_LSB   = 6;
    localparam int EXC1_RAIL_BIT   = 7;
    localparam int BIAS_LEVEL_BIT  = 7;
    localparam int SYSCTL_MON_LSB  = 5;
    localparam int SYSCTL_PREP_BIT = 0;

    // Field widths
    localparam int NUM_RAIL  = 4;
    localparam int NUM_REF   = 2;
    localparam int NUM_ROUTE = 7;

    // Reset values of the control registers
    localparam logic [7:0] RST_REFCTL = 8'h00;
    localparam logic [7:0] RST_EXC1   = 8'h00;
    localparam logic [7:0] RST_BIAS   = 8'h00;
    localparam logic [7:0] RST_SYSCTL = 8'h00;

    // Reference monitor enable field codes
    localparam logic [1:0] REFEN_OFF     = 2'h0;
    localparam logic [1:0] REFEN_RESISTOR = 2'h3;

    // Gain code that selects unity gain
    localparam logic [2:0] GAIN_UNITY = 3'h0;

    // Cycles that the register map needs to come out of reset
    localparam int READY_DELAY_CYC = 16;

    // Monitor selector codes
    typedef enum logic [2:0] {
        MON_NONE  = 3'h0,
        MON_SHORT = 3'h1,
        MON_TEMP  = 3'h2,
        MON_AVDD  = 3'h3,
        MON_DVDD  = 3'h4,
        MON_BO_02 = 3'h5,
        MON_BO_1  = 3'h6,
        MON_BO_10 = 3'h7
    } amsf_mon_e;

    // Burn-out current level codes
    localparam logic [1:0] BO_OFF = 2'h0;
    localparam logic [1:0] BO_02  = 2'h1;
    localparam logic [1:0] BO_1   = 2'h2;
    localparam logic [1:0] BO_10  = 2'h3;

    // Analog fault comparator inputs
    typedef struct packed {
        logic [NUM_RAIL-1:0] rail; // pos high, pos low, neg high, neg low
        logic [NUM_REF-1:0]  ref_low; // below third, below 300 mV
    } amsf_fault_s;

    // Analog routing and monitor controls
    typedef struct packed {
        logic                 bias_level_select;
        logic [NUM_ROUTE-1:0] bias_input_route;
        logic                 inputs_connect;
        logic                 mid_short;
        logic                 temp_sense;
        logic                 avdd_mon;
        logic                 dvdd_mon;
        logic [2:0]           eff_gain;
        logic [1:0]           burnout_current;
        logic                 bo_source_p;
        logic                 bo_sink_n;
        logic                 rail_mon_en;
        logic                 ref_det_en;
        logic                 ref_pull_res;
        logic                 prepend_status;
    } amsf_ctl_s;

endpackage : amsf_pkg

// file: verification/amsf_conv_model.sv
// Converter front-end model: conversion timing, data-ready and fault comparators
`timescale 1ns/1ps
module amsf_conv_model
    import amsf_pkg::*;
#(
    parameter int CONV_CYC = 8
) (
    // Clock and reset
    input  wire logic                  ref_clk_i,
    input  wire logic                  rst_n_i,
    // Control from the bench
    input  wire logic                  start_i,
    input  wire amsf_pkg::amsf_fault_s analog_i,
    // Towards the block
    output logic                       data_ready_n_o,
    output amsf_pkg::amsf_fault_s      fault_o,
    output logic                       busy_o
);
    logic [15:0] cnt_q;

    ////////////////////////////////////////////////////////////////////////////
    // Conversion timer; data-ready falls when a conversion completes and stays low until the next start
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q          <= 16'h0000;
            data_ready_n_o <= 1'b1;
        end else if (start_i) begin
            cnt_q          <= 16'(CONV_CYC);
            data_ready_n_o <= 1'b1;
        end else if (cnt_q == 16'h0001) begin
            cnt_q          <= 16'h0000;
            data_ready_n_o <= 1'b0;
        end else if (cnt_q != 16'h0000) begin
            cnt_q          <= cnt_q - 16'h0001;
        end
    end

    // Comparators only report while the front end is converting
    assign busy_o  = (cnt_q != 16'h0000);
    assign fault_o = busy_o ? analog_i : '0;
endmodule : amsf_conv_model

// file: verification/amsf_monitor_test.sv
// Self-checking bench for the monitor routing and fault status block
`timescale 1ns/1ps
module amsf_monitor_test;
    import amsf_pkg::*;
    localparam int RDY = 2;

    logic        ref_clk_i;
    logic        rst_n_i;
    logic        reg_wr_i;
    logic        reg_rd_i;
    logic [7:0]  reg_addr_i;
    logic [7:0]  reg_wdata_i;
    logic [7:0]  reg_rdata_o;
    logic        reg_rvalid_o;
    logic [7:0]  status_byte_o;
    logic [7:0]  rd_val;
    logic [2:0]  pga_gain_i;
    logic        conv_start;
    logic        data_ready_n;
    amsf_fault_s analog;
    amsf_fault_s fault;
    amsf_ctl_s   ctl;
    int          error_cnt;
    int          total_checks;

    ////////////////////////////////////////////////////////////////////////////
    // Block and converter model
    amsf_monitor #(.READY_CYC(RDY)) dut_u (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
        .data_ready_n_i(data_ready_n), .pga_gain_i(pga_gain_i), .fault_i(fault),
        .ctl_o(ctl), .status_byte_o(status_byte_o));
    amsf_conv_model #(.CONV_CYC(8)) conv_u (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .start_i(conv_start),
        .analog_i(analog), .data_ready_n_o(data_ready_n), .fault_o(fault), .busy_o());

    // Clock generation
    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        if (error_cnt == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : give_verdict

    task automatic tick();
        @(posedge ref_clk_i);
        #1;
    endtask : tick

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        reg_addr_i  = a;
        reg_wdata_i = d;
        reg_wr_i    = 1'b1;
        tick();
        reg_wr_i    = 1'b0;
        tick();
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        int n;
        reg_addr_i = a;
        reg_rd_i   = 1'b1;
        tick();
        reg_rd_i   = 1'b0;
        n = 0;
        while (reg_rvalid_o !== 1'b1 && n < 4) begin
            tick();
            n++;
        end
        if (n == 4) begin
            error_cnt++;
            give_verdict();
        end
        d = reg_rdata_o;
        tick();
    endtask : reg_read

    // One conversion; the fault shows only in its first cycle
    task automatic convert(input logic [5:0] f);
        int n;
        logic [7:0] pre;
        pre        = status_byte_o;
        analog     = amsf_fault_s'(f);
        conv_start = 1'b1;
        tick();
        conv_start = 1'b0;
        tick();
        analog     = '0;
        n = 0;
        while (data_ready_n !== 1'b0 && n < 64) begin
            tick();
            n++;
        end
        if (n == 64) begin
            error_cnt++;
            give_verdict();
        end
        check(status_byte_o, pre);
        repeat (3) tick();
    endtask : convert

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_startup();
        int n;
        check(status_byte_o, 8'h80);
        check({7'h0, ctl.inputs_connect}, 8'h01);
        rst_n_i = 1'b1;
        check({7'h0, status_byte_o[STAT_RDY_BIT]}, 8'h00);
        reg_write(ADDR_BIAS, 8'hff);
        n = 0;
        while (status_byte_o[STAT_RDY_BIT] !== 1'b1 && n < 40) begin
            tick();
            n++;
        end
        if (n == 40) begin
            error_cnt++;
            give_verdict();
        end
        reg_read(ADDR_BIAS, rd_val);
        check(rd_val, 8'h00);
        reg_read(ADDR_STATUS, rd_val);
        check(rd_val, 8'hc0);
        reg_write(ADDR_STATUS, 8'hff);
        reg_read(ADDR_STATUS, rd_val);
        check(rd_val, 8'hc0);
        reg_write(ADDR_STATUS, 8'h00);
        reg_read(ADDR_STATUS, rd_val);
        check(rd_val, 8'h40);
        reg_write(8'h02, 8'h5a);
        reg_read(8'h02, rd_val);
        check(rd_val, 8'h00);
    endtask : t_startup

    task automatic t_bias();
        reg_write(ADDR_BIAS, 8'hd5);
        check({ctl.bias_level_select, ctl.bias_input_route}, 8'hd5);
        reg_write(ADDR_BIAS, 8'h2a);
        check({ctl.bias_level_select, ctl.bias_input_route}, 8'h2a);
        reg_read(ADDR_BIAS, rd_val);
        check(rd_val, 8'h2a);
    endtask : t_bias

    task automatic t_selector();
        logic [2:0] s;
        logic [2:0] g;
        logic [1:0] bo;
        for (int i = 0; i < 8; i++) begin
            s  = 3'(i);
            g  = (s == 3'h3 || s == 3'h4) ? GAIN_UNITY : pga_gain_i;
            bo = (s >= 3'h5) ? 2'(s - 3'h4) : BO_OFF;
            reg_write(ADDR_SYSCTL, {s, 4'h0, s[0]});
            check({1'b0, ctl.mid_short, ctl.temp_sense, ctl.avdd_mon, ctl.dvdd_mon, ctl.eff_gain},
                  {1'b0, s == 3'h1, s == 3'h2, s == 3'h3, s == 3'h4, g});
            check({3'h0, ctl.burnout_current, ctl.bo_source_p, ctl.bo_sink_n, ctl.prepend_status},
                  {3'h0, bo, bo != 2'h0, bo != 2'h0, s[0]});
            check({7'h0, ctl.inputs_connect}, {7'h0, !(s inside {3'h1, 3'h2, 3'h3, 3'h4})});
        end
        // Burn-out sources off again before any precision measurement
        reg_write(ADDR_SYSCTL, 8'h00);
    endtask : t_selector

    task automatic t_rail();
        // Let bias settle before the first conversion
        repeat (4) tick();
        reg_write(ADDR_EXC1, 8'h00);
        convert(6'h3c);
        check({4'h0, status_byte_o[5:2]}, 8'h00);
        reg_write(ADDR_EXC1, 8'h80);
        check({7'h0, ctl.rail_mon_en}, 8'h01);
        for (int i = 0; i < 4; i++) begin
            convert(6'(4 << i));
            check({4'h0, status_byte_o[5:2]}, 8'(1 << i));
        end
        reg_read(ADDR_STATUS, rd_val);
        check(rd_val, 8'h60);
        convert(6'h00);
        check({4'h0, status_byte_o[5:2]}, 8'h00);
    endtask : t_rail

    task automatic t_reference();
        logic [1:0] f;
        for (int i = 0; i < 4; i++) begin
            f = 2'(i);
            reg_write(ADDR_REFCTL, {f, 6'h00});
            check({6'h0, ctl.ref_det_en, ctl.ref_pull_res},
                  {6'h0, f != REFEN_OFF, f == REFEN_RESISTOR});
            convert(6'h03);
            check({6'h0, status_byte_o[1:0]}, (f != REFEN_OFF) ? 8'h03 : 8'h00);
        end
        convert(6'h01);
        check({6'h0, status_byte_o[1:0]}, 8'h01);
        convert(6'h02);
        reg_read(ADDR_STATUS, rd_val);
        check(rd_val, 8'h42);
    endtask : t_reference

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        error_cnt    = 0;
        total_checks = 0;
        rst_n_i      = 1'b0;
        reg_wr_i     = 1'b0;
        reg_rd_i     = 1'b0;
        reg_addr_i   = 8'h00;
        reg_wdata_i  = 8'h00;
        conv_start   = 1'b0;
        analog       = '0;
        pga_gain_i   = 3'h2;
        repeat (8) @(posedge ref_clk_i);
        #1;
        t_startup();
        t_bias();
        t_selector();
        t_rail();
        t_reference();
        give_verdict();
    end
endmodule : amsf_monitor_test
